// File: rtl/pgmux_top.sv
// Top of the port pin mux: APB registers, input filters and per-pin function mux.
// Assumes APB from the same 200 MHz clock; pads are resolved outside from out and enable.
//
// Operation
// - Three-bit code picks filter sample period: clock over 2 up to 262144.
// - Pin 7 is general I/O unless a bus-B select bit sets I2C clock.
// - Pin 6 is general I/O unless a bus-B select bit sets I2C data.
// - Pin 5 is general I/O unless a bus-A select bit sets I2C clock.
// - Pin 4 is general I/O unless a bus-A select bit sets I2C data.
// - Pin 3 becomes channel 2 open-drain clock when that channel is enabled.
// - Pin 2 becomes channel 2 open-drain data when that channel is enabled.
// - I2C lines on pins 7 to 4 are driven low only.
// - General outputs on pins 7 to 2 are push-pull.
// - Pin n feeds interrupt n+8 when source select and enable are set.
// - Pins 1 and 0 are general I/O and feed timer and interrupt inputs.
// - Pins 1 and 0 reset timers Y and X when both clear bits set.
// - Pins 0 and 1 clock timers X and Y when external clock selected.
// - An enabled filter updates pin state only on the sampling strobe.
// - Expected-level bit selects which stable level the filter commits.
// - Direction 1 means output, 0 input; directions reset to zero.
`timescale 1ns/1ps
module pgmux_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin_out,
    output logic [7:0] o_pin_oe,
    input wire logic [7:0] i_irq_source_select,
    input wire logic [7:0] i_irq_enable_reg,
    input wire logic [5:0] i_i2c_out,
    output logic [5:0] o_i2c_in,
    input wire logic i_chan2_scl_out,
    input wire logic i_chan2_sda_out,
    output logic o_chan2_scl_in,
    output logic o_chan2_sda_in,
    output logic [7:0] o_ext_interrupt,
    output logic o_timer_x_reset_in,
    output logic o_timer_x_clock_in,
    output logic o_timer_y_reset_in,
    output logic o_timer_y_clock_in
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] pin_direction;
    logic [7:0] out_data;
    logic [7:0] noise_filter_enable;
    logic [7:0] noise_filter_expected_level;
    logic [7:0] noise_filter_sample_period;
    logic [3:0] bus_select_control;
    pgmux_pkg::pgmux_periph_s periph;
    logic [7:0] pin_input_state;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic strobe;
    logic bus_a_on;
    logic bus_b_on;
    pgmux_pkg::pgmux_pad_s next_pad;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = a == pgmux_pkg::ADDR_DIRECTION || a == pgmux_pkg::ADDR_OUT_DATA
            || a == pgmux_pkg::ADDR_PIN_STATE || a == pgmux_pkg::ADDR_FILT_ENABLE
            || a == pgmux_pkg::ADDR_FILT_LEVEL || a == pgmux_pkg::ADDR_SAMPLE_PERIOD
            || a == pgmux_pkg::ADDR_BUS_SELECT || a == pgmux_pkg::ADDR_PERIPH_CTRL;
    endfunction

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises after the first access cycle and falls after it.
    // Writes land on the edge where pready is sampled high, the same edge that takes read data.
    assign addr_ok = addr_mapped(i_paddr);
    assign wr_en = i_psel && i_penable && o_pready && i_pwrite && addr_ok;
    assign rd_en = i_psel && i_penable && !o_pready && !i_pwrite;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_direction <= pgmux_pkg::RST_BYTE;
            out_data <= pgmux_pkg::RST_BYTE;
            noise_filter_enable <= pgmux_pkg::RST_BYTE;
            noise_filter_expected_level <= pgmux_pkg::RST_BYTE;
            noise_filter_sample_period <= pgmux_pkg::RST_BYTE;
            bus_select_control <= 4'h0;
            periph <= pgmux_pkg::RST_PERIPH;
        end else if (wr_en && i_pstrb[0]) begin
            unique case (i_paddr)
                pgmux_pkg::ADDR_DIRECTION: pin_direction <= i_pwdata[7:0];
                pgmux_pkg::ADDR_PIN_STATE: pin_direction <= i_pwdata[7:0];
                pgmux_pkg::ADDR_OUT_DATA: out_data <= i_pwdata[7:0];
                pgmux_pkg::ADDR_FILT_ENABLE: noise_filter_enable <= i_pwdata[7:0];
                pgmux_pkg::ADDR_FILT_LEVEL: noise_filter_expected_level <= i_pwdata[7:0];
                // Reserved bits are stored as written; software is expected to write zero.
                pgmux_pkg::ADDR_SAMPLE_PERIOD: noise_filter_sample_period <= i_pwdata[7:0];
                pgmux_pkg::ADDR_BUS_SELECT: bus_select_control <= i_pwdata[3:0];
                pgmux_pkg::ADDR_PERIPH_CTRL: begin
                    if (i_pstrb[1]) begin
                        periph <= i_pwdata[10:0];
                    end else begin
                        periph[7:0] <= i_pwdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (i_paddr)
                pgmux_pkg::ADDR_DIRECTION: o_prdata <= {24'h000000, pin_direction};
                pgmux_pkg::ADDR_OUT_DATA: o_prdata <= {24'h000000, out_data};
                pgmux_pkg::ADDR_PIN_STATE: o_prdata <= {24'h000000, pin_input_state};
                pgmux_pkg::ADDR_FILT_ENABLE: o_prdata <= {24'h000000, noise_filter_enable};
                pgmux_pkg::ADDR_FILT_LEVEL: o_prdata <= {24'h000000, noise_filter_expected_level};
                pgmux_pkg::ADDR_SAMPLE_PERIOD: o_prdata <= {24'h000000, noise_filter_sample_period};
                pgmux_pkg::ADDR_BUS_SELECT: o_prdata <= {28'h0000000, bus_select_control};
                pgmux_pkg::ADDR_PERIPH_CTRL: o_prdata <= {21'h000000, periph};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchroniser and noise filters
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= i_pin;
            pin_sync <= pin_meta;
        end
    end

    pgmux_prescaler u_presc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sel(noise_filter_sample_period[2:0]),
        .o_strobe(strobe)
    );

    // One filter per pin; the filter tracks the pin when disabled.
    for (genvar n = 0; n < 8; n++) begin : g_filt
        pgmux_filter u_filt (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_pin(pin_sync[n]),
            .i_enable(noise_filter_enable[n]),
            .i_level(noise_filter_expected_level[n]),
            .i_strobe(strobe),
            .o_state(pin_input_state[n])
        );
    end

    // ------------------------------------------------------------
    // Pin function mux
    // ------------------------------------------------------------
    assign bus_a_on = bus_select_control[pgmux_pkg::BSEL_CH0_A]
        || bus_select_control[pgmux_pkg::BSEL_CH1_A];
    assign bus_b_on = bus_select_control[pgmux_pkg::BSEL_CH0_B]
        || bus_select_control[pgmux_pkg::BSEL_CH1_B];

    // An I2C line only ever pulls low: enable follows a low drive request.
    always_comb begin
        next_pad.out = out_data;
        next_pad.oe = pin_direction;
        if (bus_b_on) begin
            next_pad.out[7] = 1'b0;
            next_pad.oe[7] = !i_i2c_out[4];
            next_pad.out[6] = 1'b0;
            next_pad.oe[6] = !i_i2c_out[5];
        end
        if (bus_a_on) begin
            next_pad.out[5] = 1'b0;
            next_pad.oe[5] = !i_i2c_out[2];
            next_pad.out[4] = 1'b0;
            next_pad.oe[4] = !i_i2c_out[3];
        end
        if (periph.chan2_en) begin
            next_pad.out[3] = 1'b0;
            next_pad.oe[3] = !i_chan2_scl_out;
            next_pad.out[2] = 1'b0;
            next_pad.oe[2] = !i_chan2_sda_out;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin_out <= 8'h00;
            o_pin_oe <= 8'h00;
        end else begin
            o_pin_out <= next_pad.out;
            o_pin_oe <= next_pad.oe;
        end
    end

    // Peripheral inputs read the synchronised pins; idle I2C lines read high.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_i2c_in <= 6'h3F;
            o_chan2_scl_in <= 1'b1;
            o_chan2_sda_in <= 1'b1;
        end else begin
            o_i2c_in <= {bus_b_on ? pin_sync[6] : 1'b1, bus_b_on ? pin_sync[7] : 1'b1,
                bus_a_on ? pin_sync[4] : 1'b1, bus_a_on ? pin_sync[5] : 1'b1, 2'h3};
            o_chan2_scl_in <= periph.chan2_en ? pin_sync[3] : 1'b1;
            o_chan2_sda_in <= periph.chan2_en ? pin_sync[2] : 1'b1;
        end
    end

    // Interrupt and timer inputs; inactive outputs sit at 0.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_interrupt <= 8'h00;
        end else begin
            o_ext_interrupt <= pin_sync & i_irq_source_select & i_irq_enable_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_timer_x_reset_in <= 1'b0;
            o_timer_x_clock_in <= 1'b0;
            o_timer_y_reset_in <= 1'b0;
            o_timer_y_clock_in <= 1'b0;
        end else begin
            o_timer_x_reset_in <= !pin_direction[0] && (&periph.tx_clear) && pin_sync[0];
            o_timer_y_reset_in <= !pin_direction[1] && (&periph.ty_clear) && pin_sync[1];
            o_timer_x_clock_in <= !pin_direction[0]
                && periph.tx_cks == pgmux_pkg::TIMER_EXT_CLOCK && pin_sync[0];
            o_timer_y_clock_in <= !pin_direction[1]
                && periph.ty_cks == pgmux_pkg::TIMER_EXT_CLOCK && pin_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Pad and peripheral outputs are registered, so the checks hold them
    // against the controls of the cycle before.
    i2c_low_only_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(bus_b_on) && !$past(i_rst) |-> !o_pin_out[7] && !o_pin_out[6])
        else $error("bus B line driven high");

    gpio_push_pull_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !$past(bus_a_on) && !$past(i_rst) |-> o_pin_oe[4] == $past(pin_direction[4])
        && o_pin_out[4] == $past(out_data[4]))
        else $error("pin 4 general output wrong");

    chan2_od_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(periph.chan2_en) && !$past(i_rst) |-> !o_pin_out[3] && !o_pin_out[2]
        && o_pin_oe[3] == !$past(i_chan2_scl_out))
        else $error("channel 2 line not open drain");

    irq_gate_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !$past(i_irq_enable_reg[2]) && !$past(i_rst) |-> !o_ext_interrupt[2])
        else $error("interrupt passed while disabled");

    timer_clr_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_timer_x_reset_in |-> $past(periph.tx_clear) == 2'h3 && $past(pin_sync[0]))
        else $error("timer X reset without clear mode");

    bus_a_mux_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(bus_a_on) && !$past(i_rst) |-> o_pin_oe[5] == !$past(i_i2c_out[2]))
        else $error("bus A clock line mux wrong");

    bus_b_clock_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(bus_b_on) |-> o_pin_oe[7] == !$past(i_i2c_out[4]))
        else $error("bus B clock line mux wrong");

    bus_b_data_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(bus_b_on) |-> o_pin_oe[6] == !$past(i_i2c_out[5]))
        else $error("bus B data line mux wrong");

    bus_a_data_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(bus_a_on) |-> !o_pin_out[4] && o_pin_oe[4] == !$past(i_i2c_out[3]))
        else $error("bus A data line mux wrong");

    chan2_data_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(periph.chan2_en) |-> o_pin_oe[2] == !$past(i_chan2_sda_out))
        else $error("channel 2 data line mux wrong");

    gpio_pin7_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !$past(bus_b_on) |-> o_pin_oe[7] == $past(pin_direction[7])
        && o_pin_out[7] == $past(out_data[7]))
        else $error("pin 7 general port wrong");

    gpio_pin2_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !$past(periph.chan2_en) |-> o_pin_oe[2] == $past(pin_direction[2])
        && o_pin_out[2] == $past(out_data[2]))
        else $error("pin 2 general port wrong");

    irq_pass_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_ext_interrupt[7] == ($past(pin_sync[7]) && $past(i_irq_source_select[7])
        && $past(i_irq_enable_reg[7])))
        else $error("interrupt 15 gating wrong");

    timer_y_clr_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_timer_y_reset_in |-> $past(periph.ty_clear) == 2'h3
        && $past(pin_sync[1]) && !$past(pin_direction[1]))
        else $error("timer Y reset without clear mode");

    timer_x_clk_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_timer_x_clock_in |-> $past(periph.tx_cks) == pgmux_pkg::TIMER_EXT_CLOCK
        && $past(pin_sync[0]))
        else $error("timer X clock without external mode");

endmodule

// File: rtl/pgmux_pkg.sv
// Package for the port pin mux and input noise filter block.
// Assumes a single 200 MHz system clock and an APB register bus.
package pgmux_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DIRECTION = 8'h00;
    localparam logic [7:0] ADDR_OUT_DATA = 8'h04;
    localparam logic [7:0] ADDR_PIN_STATE = 8'h08;
    localparam logic [7:0] ADDR_FILT_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_FILT_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_SAMPLE_PERIOD = 8'h14;
    localparam logic [7:0] ADDR_BUS_SELECT = 8'h18;
    localparam logic [7:0] ADDR_PERIPH_CTRL = 8'h1C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BSEL_CH0_A = 0;
    localparam int BSEL_CH1_A = 1;
    localparam int BSEL_CH0_B = 2;
    localparam int BSEL_CH1_B = 3;
    localparam int PCTL_CHAN2_EN = 0;
    localparam int PCTL_TX_CLR_LO = 1;
    localparam int PCTL_TX_CKS_LO = 3;
    localparam int PCTL_TY_CLR_LO = 6;
    localparam int PCTL_TY_CKS_LO = 8;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_PERIOD = 3'h0;
    localparam logic [2:0] TIMER_EXT_CLOCK = 3'h7;
    localparam logic [10:0] RST_PERIPH = 11'h000;

    // Prescaler tap for each sampling code: divide by 2 to the power (tap + 1).
    localparam int PRESC_WIDTH = 18;
    localparam logic [4:0] TAP_000 = 5'h00;
    localparam logic [4:0] TAP_001 = 5'h04;
    localparam logic [4:0] TAP_010 = 5'h0C;
    localparam logic [4:0] TAP_011 = 5'h0D;
    localparam logic [4:0] TAP_100 = 5'h0E;
    localparam logic [4:0] TAP_101 = 5'h0F;
    localparam logic [4:0] TAP_110 = 5'h10;
    localparam logic [4:0] TAP_111 = 5'h11;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ty_cks;
        logic [1:0] ty_clear;
        logic [2:0] tx_cks;
        logic [1:0] tx_clear;
        logic chan2_en;
    } pgmux_periph_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pgmux_pad_s;

endpackage

// File: rtl/pgmux_prescaler.sv
// Free-running prescaler that pulses once per selected sampling period.
// Assumes the select field comes from a register in the same clock domain.
`timescale 1ns/1ps
module pgmux_prescaler (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_sel,
    output logic o_strobe
);

    logic [pgmux_pkg::PRESC_WIDTH-1:0] count;
    logic [pgmux_pkg::PRESC_WIDTH-1:0] mask;

    function automatic logic [4:0] tap_of(input logic [2:0] code);
        unique case (code)
            3'h0: tap_of = pgmux_pkg::TAP_000;
            3'h1: tap_of = pgmux_pkg::TAP_001;
            3'h2: tap_of = pgmux_pkg::TAP_010;
            3'h3: tap_of = pgmux_pkg::TAP_011;
            3'h4: tap_of = pgmux_pkg::TAP_100;
            3'h5: tap_of = pgmux_pkg::TAP_101;
            3'h6: tap_of = pgmux_pkg::TAP_110;
            3'h7: tap_of = pgmux_pkg::TAP_111;
        endcase
    endfunction

    // The strobe fires when every bit up to the tap is set.
    always_comb begin
        mask = ({{(pgmux_pkg::PRESC_WIDTH-1){1'b0}}, 1'b1} << (tap_of(i_sel) + 5'h01))
            - {{(pgmux_pkg::PRESC_WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= '0;
        end else begin
            count <= count + {{(pgmux_pkg::PRESC_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_strobe <= 1'b0;
        end else begin
            o_strobe <= ((count & mask) == mask);
        end
    end

    strobe_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_strobe && i_sel != 3'h0 |=> !o_strobe) else $error("strobe held over one cycle");

endmodule

// File: rtl/pgmux_filter.sv
// Per-pin input noise filter with an expected level.
// Assumes the pin has already passed a two-stage synchroniser.
`timescale 1ns/1ps
module pgmux_filter (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire logic i_enable,
    input wire logic i_level,
    input wire logic i_strobe,
    output logic o_state
);

    logic prev_sample;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_sample <= 1'b0;
        end else if (i_strobe) begin
            prev_sample <= i_pin;
        end
    end

    // Unfiltered pins follow the pin directly; filtered pins only move on a strobe:
    // to the expected level after two matching samples, to the other level after one sample.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_state <= 1'b0;
        end else if (!i_enable) begin
            o_state <= i_pin;
        end else if (i_strobe && i_pin == i_level && prev_sample == i_level) begin
            o_state <= i_level;
        end else if (i_strobe && i_pin != i_level) begin
            o_state <= ~i_level;
        end
    end

    filt_no_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_enable) && i_enable && !$past(i_strobe) |-> $stable(o_state))
        else $error("filtered state moved without strobe");

endmodule

// File: testbench/pgmux_far_side.sv
// Far side of port G: a pull-up on every pad plus external drivers.
// Assumes pad drive and enable come straight from the block under test.
`timescale 1ns/1ps
module pgmux_far_side (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_level,
    output logic [7:0] o_pad
);
    // Wired-AND over a pull-up, so a released line reads high and never holds its last value.
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            o_pad[n] = (i_oe[n] ? i_out[n] : 1'b1) & (i_ext_en[n] ? i_ext_level[n] : 1'b1);
        end
    end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the port pin mux and noise filter.
// Assumes the far-side model resolves pads; all stimulus moves at rising edges.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, err;
    logic [7:0] pad, pin_out, pin_oe, ext_irq;
    logic [7:0] irq_sel = 8'h00, irq_en = 8'h00, ext_en = 8'h00, ext_lvl = 8'h00;
    logic [5:0] i2c_out = 6'h3F, i2c_in;
    logic c2_scl = 1'b1, c2_sda = 1'b1, c2_scl_in, c2_sda_in;
    logic tx_rst, tx_clk, ty_rst, ty_clk;
    int n_fail = 0, comparisons = 0, cycles = 0;

    pgmux_top dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin(pad),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_irq_source_select(irq_sel),
        .i_irq_enable_reg(irq_en), .i_i2c_out(i2c_out), .o_i2c_in(i2c_in),
        .i_chan2_scl_out(c2_scl), .i_chan2_sda_out(c2_sda), .o_chan2_scl_in(c2_scl_in),
        .o_chan2_sda_in(c2_sda_in), .o_ext_interrupt(ext_irq), .o_timer_x_reset_in(tx_rst),
        .o_timer_x_clock_in(tx_clk), .o_timer_y_reset_in(ty_rst), .o_timer_y_clock_in(ty_clk));

    pgmux_far_side far_u (.i_out(pin_out), .i_oe(pin_oe), .i_ext_en(ext_en),
        .i_ext_level(ext_lvl), .o_pad(pad));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; request held until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, msg);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk(pgmux_pkg::ADDR_DIRECTION, 32'h0, "dir reset");
        rdchk(pgmux_pkg::ADDR_SAMPLE_PERIOD, 32'h0, "period reset");
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFF, "pins pulled up");
        chk(32'(pin_oe), 32'h0, "inputs after reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask

    task automatic t_gpio();
        apb(1'b1, pgmux_pkg::ADDR_DIRECTION, 32'hFF);
        apb(1'b1, pgmux_pkg::ADDR_OUT_DATA, 32'hA5);
        cyc(2);
        chk({16'h0, pin_oe, pin_out}, 32'hFFA5, "push-pull A5");
        apb(1'b1, pgmux_pkg::ADDR_PIN_STATE, 32'h0F);
        apb(1'b1, pgmux_pkg::ADDR_OUT_DATA, 32'h5A);
        cyc(2);
        chk({16'h0, pin_oe, pin_out}, 32'h0F5A, "dir via pin addr");
    endtask

    // Open-drain takeover of a pin pair, then release back to general output.
    task automatic t_i2c(input logic [7:0] a, input logic [31:0] v, input int hi, input int lo,
            input logic [7:0] ein);
        logic [7:0] m;
        m = (8'h01 << hi) | (8'h01 << lo);
        apb(1'b1, pgmux_pkg::ADDR_DIRECTION, 32'hFF);
        apb(1'b1, pgmux_pkg::ADDR_OUT_DATA, 32'hFF);
        apb(1'b1, a, v);
        i2c_out <= 6'h00;
        c2_scl <= 1'b0;
        c2_sda <= 1'b0;
        cyc(2);
        chk({16'h0, pin_oe, pin_out}, {16'h0, 8'hFF, ~m}, "bus pulls low");
        i2c_out <= 6'h3F;
        c2_scl <= 1'b1;
        c2_sda <= 1'b1;
        ext_en <= m;
        ext_lvl <= 8'h00;
        cyc(5);
        chk(32'(pin_oe), {24'h0, ~m}, "bus released, never high");
        chk(32'({i2c_in, c2_scl_in, c2_sda_in}), 32'(ein), "bus input levels");
        apb(1'b1, a, 32'h0);
        ext_en <= 8'h00;
        cyc(2);
        chk({16'h0, pin_oe, pin_out}, 32'hFFFF, "back to push-pull");
    endtask

    task automatic t_irq();
        apb(1'b1, pgmux_pkg::ADDR_DIRECTION, 32'h0);
        irq_sel <= 8'hF0;
        irq_en <= 8'h3C;
        cyc(5);
        chk(32'(ext_irq), 32'h30, "irq gating");
        irq_sel <= 8'hFF;
        irq_en <= 8'hFF;
        ext_en <= 8'hFF;
        ext_lvl <= 8'hA5;
        cyc(5);
        chk(32'(ext_irq), 32'hA5, "irq follows pins");
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hA5, "unfiltered state");
        irq_en <= 8'h00;
        ext_en <= 8'h00;
    endtask

    task automatic t_timer();
        ext_en <= 8'h03;
        ext_lvl <= 8'h03;
        apb(1'b1, pgmux_pkg::ADDR_PERIPH_CTRL, 32'h0C6);
        cyc(5);
        chk(32'({tx_rst, ty_rst, tx_clk, ty_clk}), 32'hC, "both clears");
        ext_lvl <= 8'h02;
        apb(1'b1, pgmux_pkg::ADDR_PERIPH_CTRL, 32'h702);
        cyc(5);
        chk(32'({tx_rst, ty_rst, tx_clk, ty_clk}), 32'h1, "one clear, y ext clock");
        ext_lvl <= 8'h01;
        apb(1'b1, pgmux_pkg::ADDR_PERIPH_CTRL, 32'h038);
        cyc(5);
        chk(32'({tx_rst, ty_rst, tx_clk, ty_clk}), 32'h2, "x ext clock");
        apb(1'b1, pgmux_pkg::ADDR_DIRECTION, 32'h01);
        cyc(5);
        chk(32'(tx_clk), 32'h0, "output pin gated");
        apb(1'b1, pgmux_pkg::ADDR_DIRECTION, 32'h0);
        apb(1'b1, pgmux_pkg::ADDR_PERIPH_CTRL, 32'h0);
    endtask

    task automatic t_filter();
        ext_en <= 8'h01;
        ext_lvl <= 8'h00;
        apb(1'b1, pgmux_pkg::ADDR_FILT_ENABLE, 32'h01);
        apb(1'b1, pgmux_pkg::ADDR_FILT_LEVEL, 32'h01);
        apb(1'b1, pgmux_pkg::ADDR_SAMPLE_PERIOD, 32'h01);
        rdchk(pgmux_pkg::ADDR_SAMPLE_PERIOD, 32'h01, "period code");
        cyc(80);
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFE, "filtered low");
        ext_lvl <= 8'h01;
        cyc(16);
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFE, "one sample only");
        cyc(80);
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFF, "stable high kept");
        apb(1'b1, pgmux_pkg::ADDR_FILT_LEVEL, 32'h00);
        ext_lvl <= 8'h00;
        cyc(80);
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFE, "stable low kept");
        apb(1'b1, pgmux_pkg::ADDR_SAMPLE_PERIOD, 32'h00);
        ext_lvl <= 8'h01;
        cyc(8);
        rdchk(pgmux_pkg::ADDR_PIN_STATE, 32'hFF, "short period");
        ext_en <= 8'h00;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gpio();
        t_i2c(pgmux_pkg::ADDR_BUS_SELECT, 32'h4, 7, 6, 8'h3F);
        t_i2c(pgmux_pkg::ADDR_BUS_SELECT, 32'h2, 5, 4, 8'hCF);
        t_i2c(pgmux_pkg::ADDR_PERIPH_CTRL, 32'h1, 3, 2, 8'hFC);
        t_irq();
        t_timer();
        t_filter();
        test_done();
    end
endmodule
